// >>> rtl/css_pkg.sv
// Constants and types shared by the contact image sensor scan sequencer.
//
// Summary of operation
// R1: Start inputs sampled on every falling pixel clock.
// R2: Controller holds global start over one fall.
// R3: Chain-in start begins scan, one pixel per clock.
// R4: Global start runs 75-clock initialization in all sensors.
// R5: First-sensor select inserts the 75-clock delay.
// R6: First sensor emits 75 dummies; active at 76.
// R7: Chain-out of one sensor starts the next.
// R8: Later sensors scan only after predecessor finishes; the code starts them at its chain-out, 9 pixels before its last.
// R9: Chain-out at pixel 1367 full, 679 half.
// R10: Chain-out at pixel 335 quarter, 163 eighth.
// R11: Last pixel 1376 full, 688 half.
// R12: Last pixel 344 quarter, 172 eighth.
// R13: Timing identical in all modes; counts differ.
// R14: Every pixel period gives one stable sample.
// R15: Controller keeps resolution fixed through the line.
package css_pkg;

    localparam int CSS_CNT_W = 11;
    localparam int CSS_PIX_W = 10;
    localparam int CSS_ADDR_W = 11;
    localparam int CSS_DEPTH = 1376;
    localparam int CSS_SYNC_N = 6;

    localparam logic [CSS_CNT_W-1:0] CSS_INIT_CLOCKS = 11'h04B;
    localparam logic [CSS_CNT_W-1:0] CSS_CNT_ONE = 11'h001;
    localparam logic [CSS_CNT_W-1:0] CSS_CNT_ZERO = 11'h000;

    localparam logic [CSS_CNT_W-1:0] CSS_LAST_FULL = 11'h560;
    localparam logic [CSS_CNT_W-1:0] CSS_LAST_HALF = 11'h2B0;
    localparam logic [CSS_CNT_W-1:0] CSS_LAST_QUARTER = 11'h158;
    localparam logic [CSS_CNT_W-1:0] CSS_LAST_EIGHTH = 11'h0AC;

    localparam logic [CSS_CNT_W-1:0] CSS_CHAIN_FULL = 11'h557;
    localparam logic [CSS_CNT_W-1:0] CSS_CHAIN_HALF = 11'h2A7;
    localparam logic [CSS_CNT_W-1:0] CSS_CHAIN_QUARTER = 11'h14F;
    localparam logic [CSS_CNT_W-1:0] CSS_CHAIN_EIGHTH = 11'h0A3;

    localparam logic [1:0] CSS_RES_FULL = 2'h0;
    localparam logic [1:0] CSS_RES_HALF = 2'h1;
    localparam logic [1:0] CSS_RES_QUARTER = 2'h2;
    localparam logic [1:0] CSS_RES_EIGHTH = 2'h3;

    localparam int CSS_S_PCLK = 0;
    localparam int CSS_S_GSTART = 1;
    localparam int CSS_S_CHAIN = 2;
    localparam int CSS_S_FIRST = 3;
    localparam int CSS_S_RES0 = 4;
    localparam int CSS_S_RES1 = 5;

    localparam int CSS_WORD_W = 1 + CSS_CNT_W + CSS_PIX_W;

    typedef enum logic [1:0] {
        CSS_IDLE = 2'b00,
        CSS_INIT = 2'b01,
        CSS_SCAN = 2'b11,
        CSS_WAIT = 2'b10
    } css_state_t;

endpackage

// >>> rtl/css_pixel_mem.sv
// Pixel hold memory with one write port and a registered read port.
`timescale 1ns/100ps
module css_pixel_mem
    import css_pkg::*;
#(
    parameter int DW = CSS_PIX_W,
    parameter int AW = CSS_ADDR_W,
    parameter int DEPTH = CSS_DEPTH
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data_r
);

    logic [DW-1:0] mem [DEPTH];

    // No reset on the array, so it maps onto block memory.
    always_ff @(posedge clock) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_r <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
        end
    end

endmodule // css_pixel_mem

// >>> rtl/css_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module css_skid_buf
    import css_pkg::*;
#(
    parameter int W = CSS_WORD_W
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid_r,
    input wire logic out_ready,
    output logic [W-1:0] out_data_r
);

    logic out_valid_nxt;
    logic [W-1:0] out_data_nxt;
    logic skid_valid_r;
    logic skid_valid_nxt;
    logic [W-1:0] skid_data_r;
    logic [W-1:0] skid_data_nxt;

    // Ready depends only on a register, so no combinational path runs back.
    assign in_ready = !skid_valid_r;

    always_comb begin
        out_valid_nxt = out_valid_r;
        out_data_nxt = out_data_r;
        skid_valid_nxt = skid_valid_r;
        skid_data_nxt = skid_data_r;
        if (out_ready || !out_valid_r) begin
            if (skid_valid_r) begin
                out_valid_nxt = 1'b1;
                out_data_nxt = skid_data_r;
                skid_valid_nxt = 1'b0;
            end else begin
                out_valid_nxt = in_valid;
                if (in_valid) begin
                    out_data_nxt = in_data;
                end
            end
        end else if (in_valid && !skid_valid_r) begin
            skid_valid_nxt = 1'b1;
            skid_data_nxt = in_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
            skid_valid_r <= 1'b0;
            skid_data_r <= '0;
        end else begin
            out_valid_r <= out_valid_nxt;
            out_data_r <= out_data_nxt;
            skid_valid_r <= skid_valid_nxt;
            skid_data_r <= skid_data_nxt;
        end
    end

endmodule // css_skid_buf

// >>> rtl/css_scan_sequencer.sv
// Scan sequencer of one cascadable contact image sensor.
`timescale 1ns/100ps
module css_scan_sequencer
    import css_pkg::*;
#(
    parameter int PIX_W = CSS_PIX_W,
    parameter int ADDR_W = CSS_ADDR_W,
    parameter int DEPTH = CSS_DEPTH
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pixel_clock,
    input wire logic global_scan_start,
    input wire logic chain_in,
    input wire logic first_sensor_select,
    input wire logic [1:0] resolution,
    input wire logic pix_wr_en,
    input wire logic [ADDR_W-1:0] pix_wr_addr,
    input wire logic [PIX_W-1:0] pix_wr_data,
    output logic video_valid,
    input wire logic video_ready,
    output logic [PIX_W-1:0] video_data,
    output logic video_dummy,
    output logic [CSS_CNT_W-1:0] video_position,
    output logic chain_out_r,
    output logic scan_busy_r
);

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [CSS_CNT_W-1:0] last_pixel(
        input logic [1:0] res
    );
        unique case (res)
            CSS_RES_FULL: last_pixel = CSS_LAST_FULL; // R11
            CSS_RES_HALF: last_pixel = CSS_LAST_HALF; // R11
            CSS_RES_QUARTER: last_pixel = CSS_LAST_QUARTER; // R12
            CSS_RES_EIGHTH: last_pixel = CSS_LAST_EIGHTH; // R12
        endcase
    endfunction

    function automatic logic [CSS_CNT_W-1:0] chain_pixel(
        input logic [1:0] res
    );
        unique case (res)
            CSS_RES_FULL: chain_pixel = CSS_CHAIN_FULL; // R9
            CSS_RES_HALF: chain_pixel = CSS_CHAIN_HALF; // R9
            CSS_RES_QUARTER: chain_pixel = CSS_CHAIN_QUARTER; // R10
            CSS_RES_EIGHTH: chain_pixel = CSS_CHAIN_EIGHTH; // R10
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // Every pin passes three flops; a level counts once stages two and
    // three agree, which rejects single-sample glitches on slow edges.
    logic [CSS_SYNC_N-1:0] sync1_r;
    logic [CSS_SYNC_N-1:0] sync2_r;
    logic [CSS_SYNC_N-1:0] sync3_r;
    logic [CSS_SYNC_N-1:0] lvl_r;
    logic [CSS_SYNC_N-1:0] lvl_nxt;
    logic [CSS_SYNC_N-1:0] pin_in;

    assign pin_in = {resolution, first_sensor_select, chain_in,
                     global_scan_start, pixel_clock};

    genvar gi;
    generate
        for (gi = 0; gi < CSS_SYNC_N; gi++) begin : g_sync
            always_comb begin
                lvl_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi]
                                                           : lvl_r[gi];
            end

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    lvl_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= pin_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    lvl_r[gi] <= lvl_nxt[gi];
                end
            end
        end
    endgenerate

    logic fall_evt;
    logic [1:0] res_lvl;

    // Start levels are sampled on every falling pixel clock edge.
    assign fall_evt = lvl_r[CSS_S_PCLK] && !lvl_nxt[CSS_S_PCLK]; // R1
    assign res_lvl = {lvl_r[CSS_S_RES1], lvl_r[CSS_S_RES0]};

    ////////////////////////////////////////////////////////////////////////

    css_state_t state_r;
    css_state_t state_nxt;
    logic [CSS_CNT_W-1:0] init_cnt_r;
    logic [CSS_CNT_W-1:0] init_cnt_nxt;
    logic [CSS_CNT_W-1:0] act_r;
    logic [CSS_CNT_W-1:0] act_nxt;
    logic [CSS_CNT_W-1:0] pos_r;
    logic [CSS_CNT_W-1:0] pos_nxt;
    logic fall_pend_r;
    logic fall_pend_nxt;
    logic fall_go;
    logic gst_cap_r;
    logic gst_cap_nxt;
    logic chn_cap_r;
    logic chn_cap_nxt;
    logic stage_v_r;
    logic stage_v_nxt;
    logic stage_dummy_r;
    logic stage_dummy_nxt;
    logic [CSS_CNT_W-1:0] stage_pos_r;
    logic [CSS_CNT_W-1:0] stage_pos_nxt;
    logic chain_out_nxt;
    logic scan_busy_nxt;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [PIX_W-1:0] rd_data;
    logic buf_in_ready;
    logic [CSS_WORD_W-1:0] buf_out;
    logic emit;
    logic emit_dummy;
    logic [CSS_CNT_W-1:0] emit_act;

    // A pixel edge waits while the previous word is still queued, so a
    // stalled receiver delays words instead of losing them.
    assign fall_go = fall_pend_r && !stage_v_r;

    // Start levels are caught at the fall itself, so a step that has to
    // wait behind a stalled word still sees the levels of its own edge.
    always_comb begin
        fall_pend_nxt = fall_pend_r;
        gst_cap_nxt = gst_cap_r;
        chn_cap_nxt = chn_cap_r;
        if (fall_go) begin
            fall_pend_nxt = 1'b0;
        end
        if (fall_evt) begin
            fall_pend_nxt = 1'b1;
            gst_cap_nxt = lvl_r[CSS_S_GSTART]; // R1
            chn_cap_nxt = lvl_r[CSS_S_CHAIN]; // R1
        end
    end

    always_comb begin
        state_nxt = state_r;
        init_cnt_nxt = init_cnt_r;
        act_nxt = act_r;
        pos_nxt = pos_r;
        chain_out_nxt = chain_out_r;
        emit = 1'b0;
        emit_dummy = 1'b0;
        emit_act = act_r;
        if (fall_go) begin
            chain_out_nxt = 1'b0;
            if (gst_cap_r) begin
                // A start held over two edges simply restarts the line.
                state_nxt = CSS_INIT; // R4
                init_cnt_nxt = CSS_CNT_ONE;
                pos_nxt = CSS_CNT_ONE;
                emit = lvl_r[CSS_S_FIRST]; // R5 R6
                emit_dummy = 1'b1;
            end else begin
                unique case (state_r)
                    CSS_IDLE, CSS_WAIT: begin
                        if (chn_cap_r) begin
                            state_nxt = CSS_SCAN; // R3 R7 R8
                            emit = 1'b1;
                            emit_act = CSS_CNT_ONE;
                            pos_nxt = CSS_CNT_ONE;
                        end
                    end
                    CSS_INIT: begin
                        if (init_cnt_r == CSS_INIT_CLOCKS) begin
                            if (lvl_r[CSS_S_FIRST]) begin
                                state_nxt = CSS_SCAN; // R6
                                emit = 1'b1;
                                emit_act = CSS_CNT_ONE;
                                pos_nxt = pos_r + CSS_CNT_ONE;
                            end else if (chn_cap_r) begin
                                state_nxt = CSS_SCAN; // R7
                                emit = 1'b1;
                                emit_act = CSS_CNT_ONE;
                                pos_nxt = CSS_CNT_ONE;
                            end else begin
                                state_nxt = CSS_WAIT; // R5 R8
                            end
                        end else begin
                            init_cnt_nxt = init_cnt_r + CSS_CNT_ONE; // R4
                            emit = lvl_r[CSS_S_FIRST]; // R6
                            emit_dummy = 1'b1;
                            pos_nxt = pos_r + CSS_CNT_ONE;
                        end
                    end
                    CSS_SCAN: begin
                        emit = 1'b1; // R3
                        emit_act = act_r + CSS_CNT_ONE;
                        pos_nxt = pos_r + CSS_CNT_ONE;
                    end
                endcase
            end
            if (emit && !emit_dummy) begin
                act_nxt = emit_act;
                if (emit_act == chain_pixel(res_lvl)) begin
                    chain_out_nxt = 1'b1; // R9 R10
                end
                if (emit_act == last_pixel(res_lvl)) begin
                    state_nxt = CSS_IDLE; // R11 R12
                end
            end
        end
    end

    // Lower resolutions read every second, fourth or eighth hold cell.
    always_comb begin
        rd_en = emit && !emit_dummy;
        rd_addr = ADDR_W'((emit_act - CSS_CNT_ONE) << res_lvl); // R13
        stage_v_nxt = stage_v_r;
        stage_dummy_nxt = stage_dummy_r;
        stage_pos_nxt = stage_pos_r;
        if (stage_v_r && buf_in_ready) begin
            stage_v_nxt = 1'b0;
        end
        if (emit) begin
            stage_v_nxt = 1'b1; // R14
            stage_dummy_nxt = emit_dummy;
            stage_pos_nxt = pos_nxt;
        end
        scan_busy_nxt = (state_nxt != CSS_IDLE) && (state_nxt != CSS_WAIT);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= CSS_IDLE;
            init_cnt_r <= CSS_CNT_ZERO;
            act_r <= CSS_CNT_ZERO;
            pos_r <= CSS_CNT_ZERO;
            fall_pend_r <= 1'b0;
            gst_cap_r <= 1'b0;
            chn_cap_r <= 1'b0;
            stage_v_r <= 1'b0;
            stage_dummy_r <= 1'b0;
            stage_pos_r <= CSS_CNT_ZERO;
            chain_out_r <= 1'b0;
            scan_busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            act_r <= act_nxt;
            pos_r <= pos_nxt;
            fall_pend_r <= fall_pend_nxt;
            gst_cap_r <= gst_cap_nxt;
            chn_cap_r <= chn_cap_nxt;
            stage_v_r <= stage_v_nxt;
            stage_dummy_r <= stage_dummy_nxt;
            stage_pos_r <= stage_pos_nxt;
            chain_out_r <= chain_out_nxt;
            scan_busy_r <= scan_busy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    css_pixel_mem #(
        .DW(PIX_W),
        .AW(ADDR_W),
        .DEPTH(DEPTH)
    ) u_mem (
        .clock(clock),
        .wr_en(pix_wr_en),
        .wr_addr(pix_wr_addr),
        .wr_data(pix_wr_data),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data_r(rd_data)
    );

    // Dummy words carry zero data; the memory output is only valid for
    // words that actually read it.
    css_skid_buf #(
        .W(CSS_WORD_W)
    ) u_buf (
        .clock(clock),
        .rstn(rstn),
        .in_valid(stage_v_r),
        .in_ready(buf_in_ready),
        .in_data({stage_dummy_r, stage_pos_r,
                  stage_dummy_r ? {PIX_W{1'b0}} : rd_data}),
        .out_valid_r(video_valid),
        .out_ready(video_ready),
        .out_data_r(buf_out)
    );

    assign video_dummy = buf_out[CSS_WORD_W-1];
    assign video_position = buf_out[CSS_WORD_W-2:PIX_W];
    assign video_data = buf_out[PIX_W-1:0];

endmodule // css_scan_sequencer

// >>> testbench/css_seq_sva.sv
// Checker for the video and chain outputs of the scan sequencer.
`timescale 1ns/100ps
module css_seq_sva (
    input wire logic clock,
    input wire logic rstn,
    input wire logic global_scan_start,
    input wire logic first_sensor_select,
    input wire logic [1:0] resolution,
    input wire logic video_valid,
    input wire logic video_ready,
    input wire logic [9:0] video_data,
    input wire logic video_dummy,
    input wire logic [10:0] video_position,
    input wire logic chain_out_r,
    input wire logic scan_busy_r
);
    logic acc;
    logic [10:0] idx, last, chn, prev_r, prev_nxt;
    assign acc = video_valid && video_ready;
    assign idx = first_sensor_select ? video_position - 11'h04B
                                     : video_position;
    assign last = resolution[1] ? (resolution[0] ? 11'h0AC : 11'h158) :
        (resolution[0] ? 11'h2B0 : 11'h560);
    assign chn = resolution[1] ? (resolution[0] ? 11'h0A3 : 11'h14F) :
        (resolution[0] ? 11'h2A7 : 11'h557);
    always_comb begin
        prev_nxt = prev_r;
        if (acc) prev_nxt = video_position;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) prev_r <= 11'h000;
        else prev_r <= prev_nxt;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_DUMMY: assert property (acc && video_dummy |->
        video_position != 11'h000 && video_position <= 11'h04B &&
        video_data == 10'h000) else $error("dummy word out of place");
    AST_FIRST: assert property (video_valid && !video_dummy &&
        first_sensor_select |-> video_position >= 11'h04C)
        else $error("active word before position 76");
    AST_LATER: assert property (video_valid && !first_sensor_select |->
        !video_dummy) else $error("dummy from a later sensor");
    AST_HOLD: assert property (video_valid && !video_ready |=>
        video_valid && $stable(video_position) && $stable(video_data) &&
        $stable(video_dummy)) else $error("stalled word changed");
    AST_INIT: assert property ($rose(global_scan_start) |->
        ##[1:16] scan_busy_r) else $error("start not taken");
    AST_STEP: assert property (acc && video_position != 11'h001 |->
        video_position == prev_r + 11'h001) else $error("position skipped");
    AST_LAST: assert property (acc && !video_dummy |->
        idx <= last) else $error("pixel beyond the last");
    AST_CHAIN: assert property ($rose(chain_out_r) |->
        ##[1:16] (acc && idx == chn)) else $error("chain-out misplaced");
    AST_END: assert property (acc && !video_dummy &&
        idx == last |-> !scan_busy_r) else $error("scan ran on");
    // The stall cover proves the hold check above was not vacuous.
    cover property (acc && video_position == 11'h04C);
    cover property ($rose(chain_out_r));
    cover property (video_valid && !video_ready);
    cover property (acc && idx == last);
endmodule // css_seq_sva

bind css_scan_sequencer css_seq_sva i_sva (.clock(clock), .rstn(rstn),
    .global_scan_start(global_scan_start),
    .first_sensor_select(first_sensor_select), .resolution(resolution),
    .video_valid(video_valid), .video_ready(video_ready),
    .video_data(video_data), .video_dummy(video_dummy),
    .video_position(video_position), .chain_out_r(chain_out_r),
    .scan_busy_r(scan_busy_r));

// >>> testbench/css_ctrl_model.sv
// Scanner controller model: pixel clock, global start and chain-in pulse.
`timescale 1ns/100ps
module css_ctrl_model (
    input wire logic clock,
    input wire logic run,
    input wire logic start_req,
    input wire logic chain_req,
    output logic pixel_clock,
    output logic global_scan_start,
    output logic chain_in,
    output int falls
);
    int ph = 0;
    logic sp = 1'b0;
    logic cp = 1'b0;
    initial pixel_clock = 1'b1;
    initial global_scan_start = 1'b0;
    initial chain_in = 1'b0;
    initial falls = 0;
    always @(posedge start_req) sp = 1'b1;
    always @(posedge chain_req) cp = 1'b1;
    // The pixel clock stands still high while no line is requested.
    always @(negedge clock) begin
        if (run || !pixel_clock) ph = ph + 1;
        if (ph == 6) begin
            ph = 0;
            pixel_clock = !pixel_clock;
            if (!pixel_clock) falls = falls + 1;
            // Pulses change only at a rise, so each spans a single fall.
            if (pixel_clock) begin
                global_scan_start = sp;
                chain_in = cp;
                sp = 1'b0;
                cp = 1'b0;
            end
        end
    end
endmodule // css_ctrl_model

// >>> testbench/css_scan_sequencer_test.sv
// Self-checking bench for the scan sequencer.
`timescale 1ns/100ps
module css_scan_sequencer_test;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic run = 1'b0, sreq = 1'b0, creq = 1'b0, fss = 1'b0, wen = 1'b0;
    logic rdy = 1'b1, stall = 1'b0, co_d = 1'b0;
    logic [1:0] res = 2'h0;
    logic [10:0] waddr = 11'h000;
    logic [9:0] wdata = 10'h000;
    logic pclk, gss, cin, vv, vd, co, busy;
    logic [9:0] vdat;
    logic [10:0] vpos;
    int falls, cyc = 0, chain_at = 0, err_total = 0, total_checks = 0;
    logic [21:0] q[$];
    always #20 clock = !clock;
    css_ctrl_model i_ctrl (.clock(clock), .run(run), .start_req(sreq),
        .chain_req(creq), .pixel_clock(pclk), .global_scan_start(gss),
        .chain_in(cin), .falls(falls));
    css_scan_sequencer i_dut (.clock(clock), .rstn(rstn), .pixel_clock(pclk),
        .global_scan_start(gss), .chain_in(cin), .first_sensor_select(fss),
        .resolution(res), .pix_wr_en(wen), .pix_wr_addr(waddr),
        .pix_wr_data(wdata), .video_valid(vv), .video_ready(rdy),
        .video_data(vdat), .video_dummy(vd), .video_position(vpos),
        .chain_out_r(co), .scan_busy_r(busy));
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (co && !co_d) chain_at = q.size();
        co_d = co;
        if (vv && rdy) q.push_back({vd, vpos, vdat});
    end
    // Stalls stay shorter than a pixel step, so no fall is ever lost.
    always @(negedge clock) begin
        cyc = cyc + 1;
        rdy = !stall || (cyc % 16 >= 5);
    end
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_falls(input int n);
        int t;
        t = falls + n;
        for (int k = 0; k < 20 * n && falls < t; k++) @(negedge clock);
        if (falls < t) begin
            err_total = err_total + 1;
            test_done;
        end
    endtask
    task automatic wait_words(input int n);
        for (int k = 0; k < 20 * n + 2000 && q.size() < n; k++)
            @(negedge clock);
        if (q.size() < n) begin
            err_total = err_total + 1;
            test_done;
        end
    endtask
    function automatic logic [21:0] word(input logic fs, input logic [1:0] r,
        input int p);
        int k;
        logic [10:0] a;
        k = fs ? p - 75 : p;
        a = 11'((k - 1) << r);
        if (k < 1) return {1'b1, p[10:0], 10'h000};
        return {1'b0, p[10:0], a[9:0] ^ 10'h2A5};
    endfunction
    task automatic check_line(input logic fs, input logic [1:0] r,
        input int n);
        check(22'(q.size()), 22'(n));
        for (int p = 1; p <= n && p <= q.size(); p++)
            check(q[p-1], word(fs, r, p));
    endtask
    task automatic begin_line(input logic fs, input logic [1:0] r);
        @(negedge clock);
        fss = fs;
        res = r;
        q.delete();
        chain_at = -1;
        run = 1'b1;
        sreq = 1'b1;
        @(negedge clock);
        sreq = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic scen_first_stall;
        stall = 1'b1;
        begin_line(1'b1, 2'h3);
        wait_words(247);
        wait_falls(4);
        stall = 1'b0;
        check_line(1'b1, 2'h3, 247);
        check({21'h0, busy}, 22'h0);
        check(22'(chain_at), 22'(75 + 163 - 1));
    endtask
    task automatic scen_later(input logic [1:0] r, input int n, input int c);
        begin_line(1'b0, r);
        wait_falls(82);
        check(22'(q.size()), 22'h0);
        creq = 1'b1;
        @(negedge clock);
        creq = 1'b0;
        wait_words(n);
        wait_falls(4);
        check_line(1'b0, r, n);
        check(22'(chain_at), 22'(c - 1));
    endtask
    initial begin
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        wen = 1'b1;
        for (int a = 0; a < 1376; a++) begin
            waddr = 11'(a);
            wdata = waddr[9:0] ^ 10'h2A5;
            @(negedge clock);
        end
        wen = 1'b0;
        scen_first_stall;
        scen_later(2'h0, 1376, 1367);
        scen_later(2'h1, 688, 679);
        scen_later(2'h2, 344, 335);
        scen_later(2'h3, 172, 163);
        test_done;
    end
endmodule // css_scan_sequencer_test
